// ---- qcadc_pkg.sv ----
/*
 Constants, types and the serial pin bundle for the four-input 8-bit
 converter frame control. Assumes one 100 MHz system clock that samples
 the serial pins, which arrive from another clock domain.
*/
package qcadc_pkg;

   localparam int CONV_CLKS    = 16;
   localparam int TRACK_CLKS   = 3;
   localparam int HOLD_FALL    = TRACK_CLKS + 1;
   localparam int RESULT_BITS  = 8;
   localparam int MSB_FALL     = HOLD_FALL;
   localparam int LSB_FALL     = MSB_FALL + RESULT_BITS - 1;
   localparam int CTRL_BITS    = 8;
   localparam int ADDR_LOW_POS = 3;
   localparam int ADDR_MID_POS = 4;
   localparam int NUM_INPUTS   = 4;

   localparam logic [1:0] DEFAULT_CHAN = 2'h0;
   localparam logic [7:0] CTRL_RESET   = 8'h00;
   localparam logic [7:0] CODE_RESET   = 8'h00;

   typedef logic [RESULT_BITS-1:0] qcadc_code_type;

   typedef struct packed {
      logic cs_n;
      logic sclk;
      logic din;
   } qcadc_pins_type;

   typedef enum logic [1:0] {
      ST_IDLE,
      ST_TRACK,
      ST_HOLD,
      ST_GAP
   } qcadc_state_type;

endpackage

// ---- qcadc_frame.sv ----
/*
 Serial frame control of the converter: synchronises chip select, serial
 clock and data in, sequences track, hold and shift-out, and captures the
 next channel address. Assumes the quantised code of each analog input
 arrives on i_code in the system clock domain, and that the serial clock
 is slow enough (a few system clocks per phase) to find its edges.
*/
module qcadc_frame (
   input  wire logic                        i_clk,
   input  wire logic                        i_rst_n,
   input  wire qcadc_pkg::qcadc_pins_type   i_pins,
   input  wire qcadc_pkg::qcadc_code_type   i_code [qcadc_pkg::NUM_INPUTS],
   output logic                             o_dout,
   output logic                             o_dout_oe,
   output logic                             o_track,
   output logic                             o_power_down,
   output logic [1:0]                       o_chan_sel
);

   qcadc_pkg::qcadc_pins_type  sync1_reg;
   qcadc_pkg::qcadc_pins_type  sync2_reg;
   qcadc_pkg::qcadc_pins_type  prev_reg;
   qcadc_pkg::qcadc_state_type state_reg;
   qcadc_pkg::qcadc_state_type state_next;
   logic [4:0]                 fall_cnt_reg;
   logic [3:0]                 rise_cnt_reg;
   logic [7:0]                 shift_reg;
   logic [1:0]                 pend_chan_reg;
   logic [1:0]                 act_chan_reg;
   qcadc_pkg::qcadc_code_type  held_reg;

   wire       cs_low   = ~sync2_reg.cs_n;
   wire       cs_fall  = prev_reg.cs_n & ~sync2_reg.cs_n;
   wire       clk_fall = prev_reg.sclk & ~sync2_reg.sclk;
   wire       clk_rise = ~prev_reg.sclk & sync2_reg.sclk;
   wire       running  = (state_reg == qcadc_pkg::ST_TRACK) ||
                         (state_reg == qcadc_pkg::ST_HOLD);
   // Gated internal clock: edges only count with select low
   wire       int_fall = cs_low & ((cs_fall & ~sync2_reg.sclk) |
                                   (clk_fall & ~cs_fall));
   wire       int_rise = cs_low & clk_rise & running;
   wire       conv_start = int_fall & ((state_reg == qcadc_pkg::ST_IDLE) ||
                                       (state_reg == qcadc_pkg::ST_GAP));
   wire [4:0] fall_nxt = conv_start ? 5'h01 : 5'(fall_cnt_reg + 5'h01);
   wire       hold_now = int_fall & running &&
                         (fall_nxt == 5'(qcadc_pkg::HOLD_FALL));
   wire [1:0] chan_now = conv_start ? pend_chan_reg : act_chan_reg;
   wire [7:0] word_in  = {shift_reg[6:0], sync2_reg.din};
   wire       word_done = int_rise &&
                          (rise_cnt_reg == 4'(qcadc_pkg::CTRL_BITS - 1));
   wire       conv_end = int_rise &&
                         (rise_cnt_reg == 4'(qcadc_pkg::CONV_CLKS - 1));
   // Sample taken at hold entry feeds the MSB in the same edge
   wire qcadc_pkg::qcadc_code_type bit_src = hold_now ? i_code[chan_now] : held_reg;

   // Bit position k of a conversion carries a result bit or zero
   function automatic logic out_bit(input qcadc_pkg::qcadc_code_type code,
                                    input logic [4:0] k);
      logic b;
      b = 1'b0;
      if (k >= 5'(qcadc_pkg::MSB_FALL) && k <= 5'(qcadc_pkg::LSB_FALL)) begin
         b = code[3'(qcadc_pkg::LSB_FALL - int'(k))];
      end
      return b;
   endfunction

   wire dout_nxt = (int_fall & (running | conv_start)) ?
                   out_bit(bit_src, fall_nxt) : o_dout;

   always_comb begin
      state_next = state_reg;
      case (state_reg)
         qcadc_pkg::ST_IDLE, qcadc_pkg::ST_GAP: begin
            if (conv_start) begin
               state_next = qcadc_pkg::ST_TRACK;
            end
         end
         qcadc_pkg::ST_TRACK: begin
            if (hold_now) begin
               state_next = qcadc_pkg::ST_HOLD;
            end
         end
         qcadc_pkg::ST_HOLD: begin
            if (conv_end) begin
               state_next = qcadc_pkg::ST_GAP;
            end
         end
         default: begin
            state_next = qcadc_pkg::ST_IDLE;
         end
      endcase
      // Deselect wins over any edge seen in the same cycle
      if (!cs_low) begin
         state_next = qcadc_pkg::ST_IDLE;
      end
   end

   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         sync1_reg <= '{cs_n: 1'b1, sclk: 1'b0, din: 1'b0};
         sync2_reg <= '{cs_n: 1'b1, sclk: 1'b0, din: 1'b0};
         prev_reg  <= '{cs_n: 1'b1, sclk: 1'b0, din: 1'b0};
      end else begin
         sync1_reg <= i_pins;
         sync2_reg <= sync1_reg;
         prev_reg  <= sync2_reg;
      end
   end

   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         state_reg <= qcadc_pkg::ST_IDLE;
      end else begin
         state_reg <= state_next;
      end
   end

   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         fall_cnt_reg <= 5'h00;
      end else if (!cs_low) begin
         fall_cnt_reg <= 5'h00;
      end else if (int_fall & (running | conv_start)) begin
         fall_cnt_reg <= fall_nxt;
      end
   end

   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         rise_cnt_reg <= 4'h0;
      end else if (!cs_low || conv_start) begin
         rise_cnt_reg <= 4'h0;
      end else if (int_rise) begin
         rise_cnt_reg <= 4'(rise_cnt_reg + 4'h1); // wraps every 16 rises
      end
   end

   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         shift_reg <= qcadc_pkg::CTRL_RESET;
      end else if (int_rise &&
                   rise_cnt_reg < 4'(qcadc_pkg::CTRL_BITS)) begin
         shift_reg <= word_in;
      end
   end

   // Pending address only takes effect at the next conversion start
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         pend_chan_reg <= qcadc_pkg::DEFAULT_CHAN;
      end else if (word_done) begin
         pend_chan_reg <= {word_in[qcadc_pkg::ADDR_MID_POS],
                           word_in[qcadc_pkg::ADDR_LOW_POS]};
      end
   end

   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         act_chan_reg <= qcadc_pkg::DEFAULT_CHAN;
         held_reg     <= qcadc_pkg::CODE_RESET;
      end else begin
         act_chan_reg <= chan_now;
         if (hold_now) begin
            held_reg <= i_code[chan_now];
         end
      end
   end

   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_dout       <= 1'b0;
         o_dout_oe    <= 1'b0;
         o_track      <= 1'b0;
         o_power_down <= 1'b1;
         o_chan_sel   <= qcadc_pkg::DEFAULT_CHAN;
      end else begin
         o_dout       <= cs_low ? dout_nxt : 1'b0;
         o_dout_oe    <= cs_low;
         o_track      <= (state_next == qcadc_pkg::ST_TRACK);
         o_power_down <= (state_next == qcadc_pkg::ST_IDLE) ||
                         (state_next == qcadc_pkg::ST_GAP);
         o_chan_sel   <= chan_now;
      end
   end

endmodule

// ---- qcadc_checker.sv ----
/* Port checker of the frame control.
   Assumes several system clocks per serial clock phase. */
module qcadc_checker (
   input wire logic                      i_clk,
   input wire logic                      i_rst_n,
   input wire qcadc_pkg::qcadc_pins_type i_pins,
   input wire qcadc_pkg::qcadc_code_type i_code [qcadc_pkg::NUM_INPUTS],
   input wire logic                      o_dout,
   input wire logic                      o_dout_oe,
   input wire logic                      o_track,
   input wire logic                      o_power_down,
   input wire logic [1:0]                o_chan_sel
);
   logic [4:0] falls;
   logic [4:0] rises;
   default clocking @(posedge i_clk); endclocking
   default disable iff (!i_rst_n);
   sequence cs_high; i_pins.cs_n [*6]; endsequence
   sequence cs_low; !i_pins.cs_n [*6]; endsequence
   // Raw pin edges: sync delay is the same for every edge
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         falls <= 5'h00;
         rises <= 5'h00;
      end else begin
         falls <= o_track ? falls + 5'($fell(i_pins.sclk)) : 5'h00;
         rises <= $rose(o_track) ? 5'h00 : rises + 5'($rose(i_pins.sclk));
      end
   end
   oe_on_select_a: assert property (cs_low |-> o_dout_oe)
      else $error("result pin not driven in frame");
   oe_off_idle_a: assert property (cs_high |-> !o_dout_oe)
      else $error("result pin driven while deselected");
   idle_power_down_a: assert property (cs_high |-> o_power_down && !o_track)
      else $error("awake while deselected");
   dout_quiet_a: assert property ((!o_dout_oe || o_track) |-> !o_dout)
      else $error("result pin not zero");
   track_on_fall_a: assert property ($fell(i_pins.cs_n) && !i_pins.sclk |-> ##[2:5] o_track)
      else $error("no track after select");
   track_wait_a: assert property ($fell(i_pins.cs_n) && i_pins.sclk |-> !o_track [*5])
      else $error("track before clock fall");
   track_len_a: assert property ($fell(o_track) && o_dout_oe |-> falls == 5'h03)
      else $error("track length wrong");
   conv_len_a: assert property ($rose(o_power_down) && o_dout_oe |-> rises == 5'h10)
      else $error("gap not at 16th rise");
   chan_hold_a: assert property (o_track [*2] |-> $stable(o_chan_sel))
      else $error("channel moved in conversion");
endmodule
bind qcadc_frame qcadc_checker chk (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_pins(i_pins),
   .i_code(i_code), .o_dout(o_dout), .o_dout_oe(o_dout_oe), .o_track(o_track),
   .o_power_down(o_power_down), .o_chan_sel(o_chan_sel));

// ---- qcadc_host.sv ----
/* Host serial port model: frames conversions and captures results.
   Assumes the bench clock; pins move on its falling edge. */
module qcadc_host (
   input  wire logic                 i_clk,
   input  wire logic                 i_dout,
   output qcadc_pkg::qcadc_pins_type o_pins
);
   timeunit 1ns;
   timeprecision 1ps;
   initial o_pins = 3'h4;
   task automatic frame(input int mode, input int n, input logic [7:0] w [4],
                        output logic [15:0] res [4]);
      o_pins.sclk = (mode != 0);
      repeat (6) @(negedge i_clk);
      o_pins.cs_n = 1'b0;
      if (mode == 2) o_pins.sclk = 1'b0;
      repeat (6) @(negedge i_clk);
      for (int c = 0; c < n; c++) begin
         for (int k = 0; k < 16; k++) begin
            o_pins.sclk = 1'b0;
            o_pins.din = (k < 8) ? w[c][7-k] : ~o_pins.din;
            repeat (6) @(negedge i_clk);
            o_pins.sclk = 1'b1;
            res[c] = {res[c][14:0], i_dout};
            repeat (6) @(negedge i_clk);
         end
      end
      o_pins.cs_n = 1'b1;
      o_pins.din = ~o_pins.din; // A released line must not keep its value
      repeat (12) @(negedge i_clk);
   endtask
endmodule

// ---- tb_quad_channel_adc_serial_frame.sv ----
/* Bench of the frame control: host frames in each clock idle mode.
   Assumes package, checker and host model compiled first. */
module tb_quad_channel_adc_serial_frame;
   timeunit 1ns;
   timeprecision 1ps;
   logic                      i_clk;
   logic                      i_rst_n;
   logic                      o_dout, o_dout_oe, o_track, o_power_down;
   logic [1:0]                o_chan_sel;
   logic [15:0]               res [4];
   qcadc_pkg::qcadc_pins_type pins;
   qcadc_pkg::qcadc_code_type codes [qcadc_pkg::NUM_INPUTS];
   int                        n_mismatch = 0;
   int                        total_checks = 0;
   qcadc_frame DUT (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_pins(pins), .i_code(codes),
      .o_dout(o_dout), .o_dout_oe(o_dout_oe), .o_track(o_track),
      .o_power_down(o_power_down), .o_chan_sel(o_chan_sel));
   qcadc_host host (.i_clk(i_clk), .i_dout(o_dout), .o_pins(pins));
   initial begin
      i_clk = 1'b0;
      forever #5 i_clk = ~i_clk;
   end
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      total_checks++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic end_sim;
      if (n_mismatch == 0 && total_checks > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   task automatic run(input int mode, input int n, input logic [7:0] w [4], input int ch [4]);
      host.frame(mode, n, w, res);
      for (int c = 0; c < n; c++)
         check(res[c], {3'h0, codes[ch[c]], 5'h00});
      check({14'h0000, o_chan_sel}, 16'(ch[n-1]));
      check({14'h0000, o_dout_oe, o_power_down}, 16'h0001);
   endtask
   initial begin
      i_rst_n = 1'b0;
      codes = '{8'hA5, 8'h3C, 8'h81, 8'h7E};
      repeat (20) @(negedge i_clk);
      i_rst_n = 1'b1;
      run(0, 4, '{8'hEF, 8'h17, 8'hD8, 8'h20}, '{0, 1, 2, 3});
      run(1, 2, '{8'h08, 8'h00, 8'h00, 8'h00}, '{0, 1, 0, 0});
      run(2, 2, '{8'h18, 8'h00, 8'h00, 8'h00}, '{0, 3, 0, 0});
      end_sim();
   end
   initial begin
      #100000;
      n_mismatch++;
      end_sim();
   end
endmodule
